// ### core/rftx_framer.sv
// Transmit framer: guard wait timing, burst, marker symbols, parity and trailer bits
`timescale 1ns/1ps
module rftx_framer (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  input  wire logic                in_valid_i,
  input  wire rftx_pkg::rftx_byte_t in_byte_i,
  output logic                     in_ready_o,
  output logic                     out_valid_o,
  output rftx_pkg::rftx_tok_t      out_tok_o,
  input  wire logic                out_ready_i,
  input  wire logic                rx_end_i,
  input  wire logic                rx_valid_i,
  input  wire rftx_pkg::rftx_rx_t  rx_byte_i,
  output logic                     rx_valid_o,
  output logic      [7:0]          rx_data_o,
  output logic                     rx_par_err_o
);
  import rftx_pkg::*;

  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h008;
    unique case (code)
      3'h0: n = 9'h008;
      3'h1: n = 9'h010;
      3'h2: n = 9'h020;
      3'h3: n = 9'h100;
      3'h4: n = 9'h030;
      3'h5: n = 9'h040;
      3'h6: n = 9'h060;
      3'h7: n = 9'h080;
    endcase
    return n;
  endfunction : burst_bits

  // Configuration registers
  logic [7:0] gctrl_q;
  logic [7:0] glow_q;
  logic [7:0] frame_q;
  logic [7:0] burst_q;
  logic [7:0] mode_q;
  logic [7:0] rate_q;
  logic       perr_q;
  logic [7:0] rdata_q;

  wire        wr_gctrl = reg_wr_i && (reg_addr_i == ADDR_GCTRL);
  wire        wr_glow  = reg_wr_i && (reg_addr_i == ADDR_GLOW);
  wire        wr_frame = reg_wr_i && (reg_addr_i == ADDR_FRAME);
  wire        wr_burst = reg_wr_i && (reg_addr_i == ADDR_BURST);
  wire        wr_mode  = reg_wr_i && (reg_addr_i == ADDR_MODE);
  wire        wr_rate  = reg_wr_i && (reg_addr_i == ADDR_RATE);
  wire        wr_stat  = reg_wr_i && (reg_addr_i == ADDR_STATUS);

  wire        ref_rx    = gctrl_q[GC_REF];
  wire        unit_rate = gctrl_q[GC_UNIT];
  wire [10:0] guard_count = {gctrl_q[GC_UP_HI:GC_UP_LO], glow_q};
  wire [2:0]  trail_sel = gctrl_q[GC_TR_HI:GC_TR_LO];
  wire        txpar_en  = frame_q[FR_TXPAR];
  wire        rxpar_en  = frame_q[FR_RXPAR];
  wire [1:0]  end_sel   = frame_q[FR_STOP_HI:FR_STOP_LO];
  wire [1:0]  begin_sel = frame_q[FR_BEG_HI:FR_BEG_LO];
  wire [8:0]  burst_len = burst_bits(burst_q[BL_HI:BL_LO]);
  wire        burst_lvl = mode_q[MD_LEVEL];
  wire        burst_en  = mode_q[MD_BURST];
  wire        type_b    = mode_q[MD_TYPEB];

  // Two-entry input buffer
  rftx_byte_t buf_q [2];
  logic       wptr_q;
  logic       rptr_q;
  logic [1:0] cnt_q;
  logic       ready_q;
  logic       pop;
  wire        push    = in_valid_i && ready_q;
  wire        buf_vld = (cnt_q != 2'd0);
  wire rftx_byte_t head = buf_q[rptr_q];
  wire [1:0]  cnt_d   = 2'(cnt_q + {1'b0, push} - {1'b0, pop});

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_entry
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          buf_q[gi] <= '0;
        end else if (push && (wptr_q == 1'(gi))) begin
          buf_q[gi] <= in_byte_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wptr_q  <= 1'b0;
      rptr_q  <= 1'b0;
      cnt_q   <= 2'd0;
      ready_q <= 1'b0;
    end else begin
      wptr_q  <= wptr_q ^ push;
      rptr_q  <= rptr_q ^ pop;
      cnt_q   <= cnt_d;
      // Registered ready looks at the next fill so a stall never overruns the buffer
      ready_q <= (cnt_d != 2'd2);
    end
  end

  // Guard wait timer
  logic [10:0] guard_q;
  logic [15:0] pre_q;
  logic        frame_done;
  wire  [15:0] rate_cyc  = (rate_q == 8'h00) ? 16'h0001 : {8'h00, rate_q};
  wire  [15:0] unit_cyc  = unit_rate ? rate_cyc : GUARD_CARRIER_CYC;
  wire         guard_ld  = ref_rx ? rx_end_i : frame_done;
  wire         guard_idle = (guard_q == 11'h000);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      guard_q <= 11'h000;
      pre_q   <= 16'h0000;
    end else if (guard_ld) begin
      guard_q <= guard_count;
      pre_q   <= 16'(unit_cyc - 16'h0001);
    end else if (!guard_idle) begin
      if (pre_q == 16'h0000) begin
        guard_q <= 11'(guard_q - 11'h001);
        pre_q   <= 16'(unit_cyc - 16'h0001);
      end else begin
        pre_q <= 16'(pre_q - 16'h0001);
      end
    end
  end

  // Frame sequencer
  rftx_state_t state_q;
  rftx_state_t state_d;
  logic [8:0]  bcnt_q;
  logic [8:0]  bcnt_d;
  logic [2:0]  tcnt_q;
  logic [2:0]  tcnt_d;
  logic        out_valid_q;
  logic        out_valid_d;
  rftx_tok_t   out_tok_q;
  rftx_tok_t   out_tok_d;

  wire         adv      = !out_valid_q || out_ready_i;
  wire         par_bit  = (^head.data) ^ PARITY_ODD;
  wire         trail_on = type_b && (trail_sel != 3'h0);
  wire rftx_state_t after_body = (end_sel != 2'h0) ? S_END :
                                 trail_on ? S_TRAIL : S_IDLE;
  wire rftx_state_t after_burst = (begin_sel != 2'h0) ? S_BEGIN : S_DATA;

  always_comb begin
    state_d     = state_q;
    bcnt_d      = bcnt_q;
    tcnt_d      = tcnt_q;
    out_tok_d   = out_tok_q;
    out_valid_d = out_valid_q && !out_ready_i;
    pop         = 1'b0;
    frame_done  = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        // Idle never ends a frame, so only the receive reference can load here
        if (buf_vld && guard_idle && !(ref_rx && rx_end_i)) begin
          bcnt_d  = 9'h000;
          tcnt_d  = 3'h0;
          state_d = burst_en ? S_BURST : after_burst;
        end
      end
      S_BURST: begin
        if (adv) begin
          out_valid_d = 1'b1;
          out_tok_d   = '{kind: TK_BURST, val: {1'b0, burst_lvl}};
          if (bcnt_q == 9'(burst_len - 9'h001)) begin
            bcnt_d  = 9'h000;
            state_d = after_burst;
          end else begin
            bcnt_d = 9'(bcnt_q + 9'h001);
          end
        end
      end
      S_BEGIN: begin
        if (adv) begin
          out_valid_d = 1'b1;
          out_tok_d   = '{kind: TK_BEGIN, val: begin_sel};
          state_d     = S_DATA;
        end
      end
      S_DATA: begin
        if (adv && buf_vld) begin
          out_valid_d = 1'b1;
          out_tok_d   = '{kind: TK_DATA, val: {1'b0, head.data[bcnt_q[2:0]]}};
          if (bcnt_q[2:0] == BYTE_LAST_BIT) begin
            bcnt_d = 9'h000;
            if (txpar_en) begin
              state_d = S_PARITY;
            end else begin
              pop     = 1'b1;
              state_d = head.last ? after_body : S_DATA;
            end
          end else begin
            bcnt_d = 9'(bcnt_q + 9'h001);
          end
        end
      end
      S_PARITY: begin
        if (adv) begin
          out_valid_d = 1'b1;
          out_tok_d   = '{kind: TK_PARITY, val: {1'b0, par_bit}};
          pop         = 1'b1;
          state_d     = head.last ? after_body : S_DATA;
        end
      end
      S_END: begin
        if (adv) begin
          out_valid_d = 1'b1;
          out_tok_d   = '{kind: TK_END, val: end_sel};
          state_d     = trail_on ? S_TRAIL : S_IDLE;
        end
      end
      S_TRAIL: begin
        if (adv) begin
          out_valid_d = 1'b1;
          // One stop bit first, then one token per extra guard unit
          out_tok_d = '{kind: (tcnt_q == 3'h0) ? TK_STOPBIT : TK_EGT, val: 2'h0};
          if (tcnt_q == 3'(trail_sel - 3'h1)) begin
            state_d = S_IDLE;
          end else begin
            tcnt_d = 3'(tcnt_q + 3'h1);
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if ((state_q != S_IDLE) && (state_d == S_IDLE)) begin
      frame_done = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q     <= S_IDLE;
      bcnt_q      <= 9'h000;
      tcnt_q      <= 3'h0;
      out_valid_q <= 1'b0;
      out_tok_q   <= '{kind: TK_BURST, val: 2'h0};
    end else begin
      state_q     <= state_d;
      bcnt_q      <= bcnt_d;
      tcnt_q      <= tcnt_d;
      out_valid_q <= out_valid_d;
      out_tok_q   <= out_tok_d;
    end
  end

  // Receive parity check
  logic       rx_valid_q;
  logic [7:0] rx_data_q;
  logic       rx_err_q;
  wire        rx_bad = rxpar_en && ((^rx_byte_i) != PARITY_ODD);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_valid_q <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_err_q   <= 1'b0;
    end else begin
      rx_valid_q <= rx_valid_i;
      rx_err_q   <= rx_valid_i && rx_bad;
      if (rx_valid_i) begin
        rx_data_q <= rx_byte_i.data;
      end
    end
  end

  // Register file
  wire [7:0] status = {5'h00, perr_q, !guard_idle, (state_q != S_IDLE)};
  wire [7:0] rd_mux =
    (reg_addr_i == ADDR_GCTRL)  ? gctrl_q :
    (reg_addr_i == ADDR_GLOW)   ? glow_q  :
    (reg_addr_i == ADDR_FRAME)  ? frame_q :
    (reg_addr_i == ADDR_BURST)  ? burst_q :
    (reg_addr_i == ADDR_MODE)   ? mode_q  :
    (reg_addr_i == ADDR_RATE)   ? rate_q  :
    (reg_addr_i == ADDR_STATUS) ? status  : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gctrl_q <= GCTRL_RST;
      glow_q  <= GLOW_RST;
      frame_q <= FRAME_RST;
      burst_q <= BURST_RST;
      mode_q  <= MODE_RST;
      rate_q  <= RATE_RST;
      rdata_q <= 8'h00;
    end else begin
      if (wr_gctrl) gctrl_q <= reg_wdata_i & GCTRL_MASK;
      if (wr_glow)  glow_q  <= reg_wdata_i;
      if (wr_frame) frame_q <= reg_wdata_i & FRAME_MASK;
      if (wr_burst) burst_q <= reg_wdata_i & BURST_MASK;
      if (wr_mode)  mode_q  <= reg_wdata_i & MODE_MASK;
      if (wr_rate)  rate_q  <= reg_wdata_i;
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  // Sticky parity error: a new error in the clearing cycle wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      perr_q <= 1'b0;
    end else if (rx_valid_i && rx_bad) begin
      perr_q <= 1'b1;
    end else if (wr_stat && reg_wdata_i[ST_PERR]) begin
      perr_q <= 1'b0;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign in_ready_o   = ready_q;
  assign out_valid_o  = out_valid_q;
  assign out_tok_o    = out_tok_q;
  assign rx_valid_o   = rx_valid_q;
  assign rx_data_o    = rx_data_q;
  assign rx_par_err_o = rx_err_q;

endmodule : rftx_framer

// ### core/rftx_pkg.sv
// Package: register map, field layout, timing constants and carrier types of the framer
package rftx_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_BURST  = 8'h30;
  localparam logic [7:0] ADDR_GCTRL  = 8'h31;
  localparam logic [7:0] ADDR_GLOW   = 8'h32;
  localparam logic [7:0] ADDR_FRAME  = 8'h33;
  localparam logic [7:0] ADDR_MODE   = 8'h3a;
  localparam logic [7:0] ADDR_RATE   = 8'h3b;
  localparam logic [7:0] ADDR_STATUS = 8'h3c;

  // Reset values and writable masks
  localparam logic [7:0] GCTRL_RST  = 8'hc0;
  localparam logic [7:0] GLOW_RST   = 8'h00;
  localparam logic [7:0] FRAME_RST  = 8'h00;
  localparam logic [7:0] BURST_RST  = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h40;
  localparam logic [7:0] GCTRL_MASK = 8'hff;
  localparam logic [7:0] FRAME_MASK = 8'hcf;
  localparam logic [7:0] BURST_MASK = 8'h70;
  localparam logic [7:0] MODE_MASK  = 8'h07;

  // Field positions
  localparam int GC_REF     = 7;
  localparam int GC_UNIT    = 6;
  localparam int GC_UP_HI   = 5;
  localparam int GC_UP_LO   = 3;
  localparam int GC_TR_HI   = 2;
  localparam int GC_TR_LO   = 0;
  localparam int FR_TXPAR   = 7;
  localparam int FR_RXPAR   = 6;
  localparam int FR_STOP_HI = 3;
  localparam int FR_STOP_LO = 2;
  localparam int FR_BEG_HI  = 1;
  localparam int FR_BEG_LO  = 0;
  localparam int BL_HI      = 6;
  localparam int BL_LO      = 4;
  localparam int MD_LEVEL   = 0;
  localparam int MD_BURST   = 1;
  localparam int MD_TYPEB   = 2;
  localparam int ST_BUSY    = 0;
  localparam int ST_GUARD   = 1;
  localparam int ST_PERR    = 2;

  // Timing: guard unit of 16 carrier periods at the core clock rate
  localparam int CLK_KHZ        = 200_000;
  localparam int CARRIER_KHZ    = 13_560;
  localparam int GUARD_PERIODS  = 16;
  localparam logic [15:0] GUARD_CARRIER_CYC =
    16'((GUARD_PERIODS * CLK_KHZ) / CARRIER_KHZ);

  localparam logic       PARITY_ODD = 1'b1;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } rftx_byte_t;

  typedef struct packed {
    logic       par;
    logic [7:0] data;
  } rftx_rx_t;

  typedef enum logic [2:0] {
    TK_BURST   = 3'b000,
    TK_BEGIN   = 3'b001,
    TK_DATA    = 3'b010,
    TK_PARITY  = 3'b011,
    TK_END     = 3'b100,
    TK_STOPBIT = 3'b101,
    TK_EGT     = 3'b110
  } rftx_kind_t;

  typedef struct packed {
    rftx_kind_t kind;
    logic [1:0] val;
  } rftx_tok_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_BURST  = 3'b001,
    S_BEGIN  = 3'b010,
    S_DATA   = 3'b011,
    S_PARITY = 3'b100,
    S_END    = 3'b101,
    S_TRAIL  = 3'b110
  } rftx_state_t;

endpackage : rftx_pkg

// ### verification/rftx_framer_sva.sv
// Checker: port-level properties of the transmit framer
`timescale 1ns/1ps
module rftx_framer_sva
  import rftx_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       in_valid_i,
  input wire rftx_byte_t in_byte_i,
  input wire logic       in_ready_o,
  input wire logic       out_valid_o,
  input wire rftx_tok_t  out_tok_o,
  input wire logic       out_ready_i,
  input wire logic       rx_end_i,
  input wire logic       rx_valid_i,
  input wire rftx_rx_t   rx_byte_i,
  input wire logic       rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_par_err_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_tok_hold: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(out_tok_o)) else $error("token dropped while stalled");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_rx_pass: assert property (rx_valid_i |=> rx_valid_o &&
    rx_data_o == $past(rx_byte_i.data)) else $error("received byte lost");
  a_rx_quiet: assert property (!rx_valid_i |=> !rx_valid_o)
    else $error("spurious receive strobe");
  a_perr_pair: assert property (rx_par_err_o |-> rx_valid_o)
    else $error("parity error without byte");
  a_begin_code: assert property (out_valid_o && out_tok_o.kind == TK_BEGIN |->
    out_tok_o.val != 2'h0) else $error("begin marker with code zero");
  a_end_code: assert property (out_valid_o && out_tok_o.kind == TK_END |->
    out_tok_o.val != 2'h0) else $error("end marker with code zero");
  a_burst_level: assert property ((out_valid_o && out_ready_i && out_tok_o.kind == TK_BURST)
    ##1 (out_valid_o && out_tok_o.kind == TK_BURST) |-> $stable(out_tok_o.val))
    else $error("burst level changed");
  c_burst: cover property (out_valid_o && out_ready_i && out_tok_o.kind == TK_BURST);
  c_parity: cover property (out_valid_o && out_ready_i && out_tok_o.kind == TK_PARITY);
  c_egt: cover property (out_valid_o && out_ready_i && out_tok_o.kind == TK_EGT);
  c_perr: cover property (rx_par_err_o);
endmodule : rftx_framer_sva

bind rftx_framer rftx_framer_sva i_sva (.*);

// ### verification/rftx_tag_model.sv
// Partner: token consumer standing for the tag across the field
`timescale 1ns/1ps
module rftx_tag_model
  import rftx_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      rst_i,
  input  wire logic      slow_i,
  input  wire logic      stop_i,
  input  wire logic      valid_i,
  input  wire rftx_tok_t tok_i,
  output logic           ready_o
);
  rftx_tok_t got[$];
  int        tq[$];
  int        cyc = 0;
  logic      ph_q = 1'b0;
  // Slow mode takes every other cycle, so the framer must hold each token
  assign ready_o = !stop_i && (!slow_i || ph_q);
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    ph_q <= rst_i ? 1'b0 : ~ph_q;
    if (!rst_i && valid_i && ready_o) begin
      got.push_back(tok_i);
      tq.push_back(cyc);
    end
  end
endmodule : rftx_tag_model

// ### verification/tb.sv
// Testbench: registers, frame tokens, guard timing and receive path
`timescale 1ns/1ps
module tb;
  import rftx_pkg::*;
  logic       core_clk_i, rst_i, reg_wr_i, reg_rd_i, in_valid_i, in_ready_o;
  logic       out_valid_o, out_ready_i, rx_end_i, rx_valid_i, rx_valid_o, rx_par_err_o;
  logic       slow, stop;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rx_data_o, md, fr, gc, d;
  logic [2:0] bc;
  rftx_byte_t in_byte_i;
  rftx_rx_t   rx_byte_i;
  rftx_tok_t  out_tok_o;
  rftx_tok_t  exp[$];
  int         bad_count = 0, n_checks = 0, tcnt = 0, t0, g;
  int         bl[8] = '{8, 16, 32, 256, 48, 64, 96, 128};

  rftx_framer i_dut (.*);
  rftx_tag_model i_tag (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow), .stop_i(stop),
    .valid_i(out_valid_o), .tok_i(out_tok_o), .ready_o(out_ready_i));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    // Read data stand only until the next edge, so take them mid-cycle
    @(negedge core_clk_i);
    v = reg_rdata_o;
    @(posedge core_clk_i);
  endtask : rd

  task automatic cfg(input logic [7:0] m, input logic [2:0] c, input logic [7:0] f,
                     input logic [7:0] q);
    md = m;
    bc = c;
    fr = f;
    gc = q;
    wr(8'h3a, m);
    wr(8'h30, {1'b0, c, 4'h0});
    wr(8'h33, f);
    wr(8'h31, q);
  endtask : cfg

  function automatic void put(input rftx_kind_t k, input logic [1:0] v);
    exp.push_back('{kind: k, val: v});
  endfunction : put

  // Expected token order is built from the settings, then the bytes are offered
  task automatic send(input int n, input logic [7:0] b0);
    logic [7:0] b;
    logic [1:0] m;
    int         w;
    exp.delete();
    i_tag.got.delete();
    i_tag.tq.delete();
    if (md[1]) repeat (bl[bc]) put(TK_BURST, {1'b0, md[0]});
    if (fr[1:0] != 2'h0) put(TK_BEGIN, fr[1:0]);
    for (int i = 0; i < n; i++) begin
      b = b0 + 8'(i);
      for (int j = 0; j < 8; j++) put(TK_DATA, {1'b0, b[j]});
      if (fr[7]) put(TK_PARITY, {1'b0, ~^b});
    end
    if (fr[3:2] != 2'h0) put(TK_END, fr[3:2]);
    if (md[2] && gc[2:0] != 3'h0) begin
      put(TK_STOPBIT, 2'h0);
      repeat (gc[2:0] - 1) put(TK_EGT, 2'h0);
    end
    for (int i = 0; i < n; i++) begin
      in_valid_i <= 1'b1;
      in_byte_i <= '{last: (i == n - 1), data: b0 + 8'(i)};
      do @(posedge core_clk_i); while (in_ready_o !== 1'b1);
    end
    in_valid_i <= 1'b0;
    w = 0;
    while (i_tag.got.size() < exp.size() && w < 20000) begin
      @(posedge core_clk_i);
      w++;
    end
    chk("token count", exp.size(), i_tag.got.size());
    foreach (exp[k]) begin
      m = (exp[k].kind inside {TK_BEGIN, TK_END}) ? 2'h3 : (exp[k].kind <= TK_PARITY);
      if (k < i_tag.got.size())
        chk("token", {exp[k].kind, exp[k].val & m}, {i_tag.got[k].kind, i_tag.got[k].val & m});
    end
  endtask : send

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    tcnt++;
    if (tcnt == 60000) begin
      bad_count++;
      $display("mismatch timeout expected %0d seen %0d", 59999, tcnt);
      final_report();
    end
  end

  initial begin
    {rst_i, reg_wr_i, reg_rd_i, in_valid_i, rx_end_i, rx_valid_i, slow, stop} = 8'h80;
    {reg_addr_i, reg_wdata_i, in_byte_i, rx_byte_i} = '0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h31, d);
    chk("guard control", 8'hc0, d);
    rd(8'h40, d);
    chk("unmapped", 8'h00, d);
    wr(8'h33, 8'hff);
    rd(8'h33, d);
    chk("frame control", 8'hcf, d);
    wr(8'h30, 8'hff);
    rd(8'h30, d);
    chk("burst length", 8'h70, d);
    $display("test registers done");
    slow <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      cfg(8'h00, 3'h0, {c[0], 3'h0, 2'(c), 2'(3 - c)}, 8'hc0);
      send(2, 8'ha5);
    end
    slow <= 1'b0;
    $display("test markers done");
    for (int c = 0; c < 8; c++) begin
      cfg(8'h02 | 8'(c & 1), 3'(c), 8'h00, 8'hc0);
      send(1, 8'h3c);
    end
    $display("test burst done");
    for (int c = 0; c < 8; c++) begin
      cfg(8'h04, 3'h0, 8'h00, 8'hc0 | 8'(c));
      send(1, 8'h81);
    end
    cfg(8'h00, 3'h0, 8'h00, 8'hc5);
    send(1, 8'h81);
    $display("test trailer done");
    // Tag stalled: the two-entry buffer must refuse, then lose nothing
    stop <= 1'b1;
    fork
      send(4, 8'h10);
      begin
        repeat (60) @(posedge core_clk_i);
        chk("in ready", 0, in_ready_o);
        stop <= 1'b0;
      end
    join
    $display("test buffer done");
    wr(8'h3b, 8'h02);
    wr(8'h32, 8'h04);
    cfg(8'h00, 3'h0, 8'h00, 8'hc8);
    send(1, 8'h11);
    t0 = i_tag.tq[$];
    send(1, 8'h22);
    chk("no guard after send", 1, 32'(i_tag.tq[0] - t0 <= 10));
    rx_end_i <= 1'b1;
    @(posedge core_clk_i);
    rx_end_i <= 1'b0;
    t0 = i_tag.cyc;
    send(1, 8'h33);
    g = i_tag.tq[0] - t0;
    chk("guard after receive", 1, 32'(g >= 520 && g <= 530));
    wr(8'h32, 8'h03);
    cfg(8'h00, 3'h0, 8'h00, 8'h00);
    send(1, 8'h44);
    t0 = i_tag.tq[$];
    send(1, 8'h55);
    g = i_tag.tq[0] - t0;
    chk("guard in carrier units", 1, 32'(g >= 705 && g <= 715));
    $display("test guard done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h33, k < 2 ? 8'h40 : 8'h00);
      rx_valid_i <= 1'b1;
      rx_byte_i <= '{par: (k == 1), data: 8'h03};
      @(posedge core_clk_i);
      rx_valid_i <= 1'b0;
      // The receive strobes stand for one cycle only; rx_data_o holds until the next byte
      @(negedge core_clk_i);
      chk("rx out", {1'b1, 8'h03, k == 0}, {rx_valid_o, rx_data_o, rx_par_err_o});
      @(posedge core_clk_i);
    end
    rd(8'h3c, d);
    chk("parity flag", 1, d[2]);
    wr(8'h3c, 8'h04);
    rd(8'h3c, d);
    chk("parity flag clear", 0, d[2]);
    $display("test receive done");
    final_report();
  end
endmodule : tb
